//--- gcmcr_pkg.sv
// Shared constants for the channel-1 gain calibration and map checksum slice
package gcmcr_pkg;

  // Bus geometry: each register takes one aligned 32-bit word
  localparam int AVS_ADDR_W = 8;
  localparam int AVS_DATA_W = 32;
  localparam int AVS_BE_W   = 4;
  localparam int REG_W      = 16;
  localparam int IDX_W      = 6;
  localparam int IDX_LSB    = 2;    // Byte address is four times the register index

  // Register indices as printed in the map
  localparam logic [5:0] IDX_GAIN_UPPER = 6'h11;
  localparam logic [5:0] IDX_GAIN_LOWER = 6'h12;
  localparam logic [5:0] IDX_CHECKSUM   = 6'h3E;
  localparam logic [5:0] IDX_RESERVED   = 6'h3F;

  // Gain value layout: unsigned fraction, full scale just below 2.0
  localparam int GAIN_W        = 24;
  localparam int GAIN_FRAC_W   = 23;  // One integer bit, 23 fraction bits
  localparam int GAIN_HIGH_POS = 8;   // Upper word holds gain [23:8]
  localparam int GAIN_LOW_W    = 8;   // Lower word holds gain [7:0]
  localparam int GAIN_LOW_POS  = 8;   // ... in bits [15:8] of the lower word

  // Reset values
  localparam logic [15:0] RST_GAIN_UPPER = 16'h8000;
  localparam logic [7:0]  RST_GAIN_LOW   = 8'h00;
  localparam logic [15:0] RST_CHECKSUM   = 16'h0000;
  localparam logic [15:0] RST_RESERVED   = 16'h0000;
  localparam logic [7:0]  RSVD_LOW_BYTE  = 8'h00;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

  // Checksum polynomial and seed
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam int          CRC_IN_W = 40;

  // Bus handshake states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_ACK
  } gcmcr_bus_state_e;

endpackage : gcmcr_pkg

//--- gcmcr_crc.sv
`timescale 1ns/1ps
// Checksum over the stored map contents, bit-serial CRC unrolled in one cycle
module gcmcr_crc #(
  parameter int DATA_W = gcmcr_pkg::CRC_IN_W
) (
  input  wire logic [DATA_W-1:0] data,
  output logic      [15:0]       crc
);

  // Shift one bit at a time, most significant bit first
  always_comb begin
    logic [15:0] acc;
    logic        fb;
    acc = gcmcr_pkg::CRC_SEED;
    fb  = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb  = acc[15] ^ data[i];
      acc = {acc[14:0], 1'b0};
      if (fb) begin
        acc = acc ^ gcmcr_pkg::CRC_POLY;
      end
    end
    crc = acc;
  end

endmodule : gcmcr_crc

//--- gcmcr_regs.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// - Upper gain word holds gain bits 23..8, all sixteen bits read and write.
// - Lower gain word holds gain bits 7..0 high; low byte reads zero, ignores writes.
// - Combined 24-bit gain is an unsigned fraction from zero to just under two.
// - Upper gain word at index 11h resets to 8000h, unity gain.
// - Lower gain word at index 12h resets to 0000h.
// - Read-only checksum word at index 3Eh reports the map checksum; writes ignored.
// - Checksum word reads 0000h straight after reset.
module gcmcr_regs #(
  parameter int ADDR_W = gcmcr_pkg::AVS_ADDR_W
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire logic [ADDR_W-1:0]               address,
  input  wire logic                            read,
  input  wire logic                            write,
  input  wire logic [gcmcr_pkg::AVS_DATA_W-1:0] writedata,
  input  wire logic [gcmcr_pkg::AVS_BE_W-1:0]   byteenable,
  output logic      [gcmcr_pkg::AVS_DATA_W-1:0] readdata,
  output logic                                 waitrequest,
  output logic      [gcmcr_pkg::GAIN_W-1:0]     gainCorrection,
  output logic      [gcmcr_pkg::REG_W-1:0]      mapChecksum
);

  // Merge write data into a 16-bit word by the two low byte enables
  function automatic logic [15:0] mergeLanes(
    input logic [15:0] oldWord,
    input logic [15:0] newWord,
    input logic [1:0]  lanes
  );
    logic [15:0] res;
    res = oldWord;
    if (lanes[0]) begin
      res[7:0] = newWord[7:0];
    end
    if (lanes[1]) begin
      res[15:8] = newWord[15:8];
    end
    return res;
  endfunction : mergeLanes

  // Register index from a byte address
  function automatic logic [gcmcr_pkg::IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] addr);
    return addr[gcmcr_pkg::IDX_LSB +: gcmcr_pkg::IDX_W];
  endfunction : regIndex

  // Zero-extend one register word onto the read bus
  function automatic logic [gcmcr_pkg::AVS_DATA_W-1:0] widenWord(input logic [gcmcr_pkg::REG_W-1:0] word);
    return {{(gcmcr_pkg::AVS_DATA_W - gcmcr_pkg::REG_W){1'b0}}, word};
  endfunction : widenWord

  // Software view of one register; unmapped indices read as zero
  function automatic logic [gcmcr_pkg::AVS_DATA_W-1:0] readWord(
    input logic [gcmcr_pkg::IDX_W-1:0] index,
    input logic [gcmcr_pkg::REG_W-1:0] upperWord,
    input logic [gcmcr_pkg::REG_W-1:0] lowerWord,
    input logic [gcmcr_pkg::REG_W-1:0] checkWord,
    input logic [gcmcr_pkg::REG_W-1:0] spareWord
  );
    logic [gcmcr_pkg::AVS_DATA_W-1:0] res;
    res = gcmcr_pkg::UNMAPPED_READ;
    unique case (index)
      gcmcr_pkg::IDX_GAIN_UPPER: res = widenWord(upperWord);
      gcmcr_pkg::IDX_GAIN_LOWER: res = widenWord(lowerWord);
      gcmcr_pkg::IDX_CHECKSUM:   res = widenWord(checkWord);
      gcmcr_pkg::IDX_RESERVED:   res = widenWord(spareWord);
      default:                   res = gcmcr_pkg::UNMAPPED_READ;
    endcase
    return res;
  endfunction : readWord

  // Join both stored fields into the unsigned gain, one integer bit
  function automatic logic [gcmcr_pkg::GAIN_W-1:0] joinGain(
    input logic [gcmcr_pkg::REG_W-1:0]      highPart,
    input logic [gcmcr_pkg::GAIN_LOW_W-1:0] lowPart
  );
    return {highPart, lowPart};
  endfunction : joinGain

  // Stored state
  gcmcr_pkg::gcmcr_bus_state_e        state;
  gcmcr_pkg::gcmcr_bus_state_e        next_state;
  logic                               next_waitrequest;
  logic [gcmcr_pkg::AVS_DATA_W-1:0]   next_readdata;
  logic [gcmcr_pkg::REG_W-1:0]        gainHigh;
  logic [gcmcr_pkg::REG_W-1:0]        next_gainHigh;
  logic [gcmcr_pkg::GAIN_LOW_W-1:0]   gainLow;
  logic [gcmcr_pkg::GAIN_LOW_W-1:0]   next_gainLow;
  logic [gcmcr_pkg::REG_W-1:0]        reservedWord;
  logic [gcmcr_pkg::REG_W-1:0]        next_reservedWord;
  logic [gcmcr_pkg::REG_W-1:0]        next_mapChecksum;
  logic [gcmcr_pkg::GAIN_W-1:0]       next_gainCorrection;

  // Decode helpers
  logic [gcmcr_pkg::IDX_W-1:0]        idx;
  logic                               wrTaken;
  logic                               mapWritten;
  logic [gcmcr_pkg::REG_W-1:0]        wrWord;
  logic [gcmcr_pkg::REG_W-1:0]        lowerMerged;
  logic [gcmcr_pkg::REG_W-1:0]        lowerView;
  logic [gcmcr_pkg::REG_W-1:0]        crcValue;

  assign idx     = regIndex(address);
  assign wrWord  = writedata[gcmcr_pkg::REG_W-1:0];
  // A write lands only at the edge where waitrequest is seen low
  assign wrTaken = (state == gcmcr_pkg::ST_ACK) && write;

  // Lower word as software sees it: low byte always zero
  assign lowerView = {gainLow, gcmcr_pkg::RSVD_LOW_BYTE};

  // Bus handshake: one wait cycle, then a single-cycle acknowledge
  always_comb begin
    next_state       = state;
    next_waitrequest = 1'b1;
    next_readdata    = readdata;
    unique case (state)
      gcmcr_pkg::ST_IDLE: begin
        if (read || write) begin
          next_state       = gcmcr_pkg::ST_ACK;
          next_waitrequest = 1'b0;
        end
        if (read) begin
          // Data captured here stands at the acknowledge edge and after
          next_readdata = readWord(idx, gainHigh, lowerView, mapChecksum, reservedWord);
        end
      end
      gcmcr_pkg::ST_ACK: begin
        // Master releases after this edge; never re-acknowledge the same request
        next_state = gcmcr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state       <= gcmcr_pkg::ST_IDLE;
      waitrequest <= 1'b1;
      readdata    <= gcmcr_pkg::UNMAPPED_READ;
    end else begin
      state       <= next_state;
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
    end
  end

  // Register writes; unmapped and read-only targets are dropped silently
  always_comb begin
    next_gainHigh     = gainHigh;
    next_gainLow      = gainLow;
    next_reservedWord = reservedWord;
    lowerMerged       = mergeLanes(lowerView, wrWord, byteenable[1:0]);
    mapWritten        = 1'b0;
    if (wrTaken) begin
      unique case (idx)
        gcmcr_pkg::IDX_GAIN_UPPER: begin
          next_gainHigh = mergeLanes(gainHigh, wrWord, byteenable[1:0]);
          mapWritten    = 1'b1;
        end
        gcmcr_pkg::IDX_GAIN_LOWER: begin
          // Only the upper byte is stored, so low-byte data is lost on purpose
          next_gainLow = lowerMerged[gcmcr_pkg::GAIN_LOW_POS +: gcmcr_pkg::GAIN_LOW_W];
          mapWritten   = 1'b1;
        end
        gcmcr_pkg::IDX_RESERVED: begin
          // Stored as written; software is expected to keep it zero
          next_reservedWord = mergeLanes(reservedWord, wrWord, byteenable[1:0]);
          mapWritten        = 1'b1;
        end
        default: begin
          // Checksum word and unmapped indices keep their state
          mapWritten = 1'b0;
        end
      endcase
    end
  end

  // Checksum computed over the values that will be stored after this edge
  gcmcr_crc #(
    .DATA_W (gcmcr_pkg::CRC_IN_W)
  ) u_crc (
    .data ({next_gainHigh, next_gainLow, next_reservedWord}),
    .crc  (crcValue)
  );

  // Derived outputs: gain for the datapath, checksum held between map writes
  always_comb begin
    next_gainCorrection = joinGain(next_gainHigh, next_gainLow);
    next_mapChecksum    = mapChecksum;
    if (mapWritten) begin
      // Only a map write moves it, so it reads 0000h until the first one
      // Trade-off: software must not trust it before that first write
      next_mapChecksum = crcValue;
    end
  end

  // Stored register words
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gainHigh     <= gcmcr_pkg::RST_GAIN_UPPER;
      gainLow      <= gcmcr_pkg::RST_GAIN_LOW;
      reservedWord <= gcmcr_pkg::RST_RESERVED;
    end else begin
      gainHigh     <= next_gainHigh;
      gainLow      <= next_gainLow;
      reservedWord <= next_reservedWord;
    end
  end

  // Output flops, updated at the same edge as the write that feeds them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mapChecksum    <= gcmcr_pkg::RST_CHECKSUM;
      gainCorrection <= joinGain(gcmcr_pkg::RST_GAIN_UPPER, gcmcr_pkg::RST_GAIN_LOW);
    end else begin
      mapChecksum    <= next_mapChecksum;
      gainCorrection <= next_gainCorrection;
    end
  end

endmodule : gcmcr_regs

//--- gcmcr_regs_checker.sv
`timescale 1ns/1ps
// Port-level checks of the gain and checksum register slice
module gcmcr_regs_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [23:0] gainCorrection,
  input wire logic [15:0] mapChecksum
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Acknowledge edge and register index
  wire       ack = (read | write) & !waitrequest;
  wire [5:0] idx = address[7:2];
  a_ack_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("acknowledge not one cycle");
  a_upper_gain_write: assert property (ack && write && idx == 6'h11 && byteenable[1:0] == 2'h3
    |=> gainCorrection[23:8] == $past(writedata[15:0])) else $error("upper gain not written");
  a_lower_gain_write: assert property (ack && write && idx == 6'h12 && byteenable[1]
    |=> gainCorrection[7:0] == $past(writedata[15:8])) else $error("lower gain not written");
  a_lower_read_zero: assert property (ack && read && idx == 6'h12
    |-> readdata == {16'h0000, gainCorrection[7:0], 8'h00}) else $error("lower gain word wrong");
  a_upper_read_back: assert property (ack && read && idx == 6'h11
    |-> readdata == {16'h0000, gainCorrection[23:8]}) else $error("upper gain word wrong");
  a_reset_values: assert property ($past(rst)
    |-> gainCorrection == 24'h800000 && mapChecksum == 16'h0000) else $error("reset values wrong");
  a_checksum_read: assert property (ack && read && idx == 6'h3E
    |-> readdata == {16'h0000, mapChecksum}) else $error("checksum word wrong");
  a_checksum_hold: assert property (!(ack && write && idx inside {6'h11, 6'h12, 6'h3F})
    |=> $stable(mapChecksum)) else $error("checksum moved without write");
  c_upper_write: cover property (ack && write && idx == 6'h11);
  c_checksum_write: cover property (ack && write && idx == 6'h3E);
  c_lower_read: cover property (ack && read && idx == 6'h12);
endmodule : gcmcr_regs_checker

bind gcmcr_regs gcmcr_regs_checker chk_u (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .gainCorrection(gainCorrection), .mapChecksum(mapChecksum));

//--- test_gain_cal_and_map_crc_regs.sv
`timescale 1ns/1ps
module test_gain_cal_and_map_crc_regs;
  logic        core_clk, rst, read, write, waitrequest;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [23:0] gainCorrection;
  logic [15:0] mapChecksum, mUp, mRsv, mCrc, d;
  logic [7:0]  mLow;
  logic [5:0]  idxs [5] = '{6'h11, 6'h12, 6'h3E, 6'h3F, 6'h05};
  logic [5:0]  ix;
  int          error_cnt, num_checks, seed;
  gcmcr_regs dut_u (.core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .gainCorrection(gainCorrection), .mapChecksum(mapChecksum));
  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Own CRC model, MSB first, so a shared slip cannot hide
  function automatic logic [15:0] crc16(input logic [39:0] v);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 39; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc16
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] i, input logic [15:0] v, input logic [3:0] be);
    @(posedge core_clk);
    read <= !wr;
    write <= wr;
    address <= {i, 2'h0};
    writedata <= {16'h0000, v};
    byteenable <= be;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] i, input logic [15:0] v, input logic [3:0] be);
    bus(1'b1, i, v, be);
    if (i == 6'h11 && be[0]) mUp[7:0] = v[7:0];
    if (i == 6'h11 && be[1]) mUp[15:8] = v[15:8];
    if (i == 6'h12 && be[1]) mLow = v[15:8];
    if (i == 6'h3F && be[0]) mRsv[7:0] = v[7:0];
    if (i == 6'h3F && be[1]) mRsv[15:8] = v[15:8];
    if (i inside {6'h11, 6'h12, 6'h3F}) mCrc = crc16({mUp, mLow, mRsv});
  endtask : wr
  // Read every word, including an unmapped one, against the model
  task automatic check_all;
    bus(1'b0, 6'h11, 16'h0000, 4'h0);
    check("gain upper", rd, {16'h0000, mUp});
    bus(1'b0, 6'h12, 16'h0000, 4'h0);
    check("gain lower", rd, {16'h0000, mLow, 8'h00});
    bus(1'b0, 6'h3E, 16'h0000, 4'h0);
    check("checksum", rd, {16'h0000, mCrc});
    bus(1'b0, 6'h3F, 16'h0000, 4'h0);
    check("reserved", rd, {16'h0000, mRsv});
    bus(1'b0, 6'h05, 16'h0000, 4'h0);
    check("unmapped", rd, 32'h0000_0000);
    check("gain port", {8'h00, gainCorrection}, {8'h00, mUp, mLow});
    check("checksum port", {16'h0000, mapChecksum}, {16'h0000, mCrc});
  endtask : check_all
  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    {mUp, mLow, mRsv, mCrc} = {16'h8000, 8'h00, 16'h0000, 16'h0000};
  endtask : do_reset
  // Watchdog, far beyond the roughly 800 cycles needed
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence: reset, full scale, random traffic, reset again
  initial begin
    {rst, read, write, address, writedata, byteenable} = {1'b1, 46'h0};
    seed = 39;
    do_reset();
    check_all();
    wr(6'h11, 16'hFFFF, 4'h3);
    wr(6'h12, 16'hFFFF, 4'h3);
    check_all();
    repeat (40) begin
      ix = idxs[$unsigned($random(seed)) % 5];
      d = 16'($random(seed));
      wr(ix, (ix == 6'h3F) ? 16'h0000 : d, 4'($random(seed)));
      check_all();
    end
    do_reset();
    check_all();
    tally_and_finish();
  end
endmodule : test_gain_cal_and_map_crc_regs
